// ===== sync_serial_consts.svh
// constants for the clocked synchronous serial channel
`ifndef SYNC_SERIAL_CONSTS_SVH
`define SYNC_SERIAL_CONSTS_SVH

`define SS_DATA_W 8
`define SS_DIV_W 8
`define SS_CNT_W 4
`define SS_LAST_BIT 4'h7
`define SS_TX_EMPTY_RST 1'b1
`define SS_TX_END_RST 1'b1
`define SS_TXD_RST 1'b1
`define SS_SCK_RST 1'b1
`define SS_IRQ_NONE 3'h0
`define SS_IRQ_RX_ERROR 3'h1
`define SS_IRQ_RX_FULL 3'h2
`define SS_IRQ_TX_EMPTY 3'h3
`define SS_IRQ_TX_END 3'h4

`endif

// ===== sync_serial_pkg.sv
// types shared by the serial channel and its pin synchroniser
`default_nettype none
`include "sync_serial_consts.svh"
package sync_serial_pkg;

    typedef struct packed {
        logic tx_enable;
        logic rx_enable;
        logic tx_irq_enable;
        logic rx_irq_enable;
        logic tx_end_irq_enable;
        logic clk_internal;
    } ctrl_s;

    typedef struct packed {
        logic tx_empty;
        logic tx_end;
        logic rx_full;
        logic overrun;
        logic framing_err;
        logic parity_err;
    } flags_s;

    typedef struct packed {
        logic rx_error;
        logic rx_full;
        logic tx_empty;
        logic tx_end;
    } requests_s;

    typedef enum logic [1:0] {ST_IDLE, ST_RUN} link_state_e;

    typedef struct packed {
        link_state_e st;
        logic [`SS_DATA_W-1:0] tx_buf;
        logic [`SS_DATA_W-1:0] tx_shift;
        logic [`SS_DATA_W-1:0] rx_shift;
        logic [`SS_DATA_W-1:0] rx_buf;
        logic [`SS_CNT_W-1:0] bit_cnt;
        logic [`SS_DIV_W-1:0] div;
        logic tx_live;
        logic chain;
        logic txd;
        logic sck;
        flags_s flags;
    } chan_state_s;

    typedef struct packed {
        logic [2:0] sck;
        logic [1:0] rxd;
    } pin_sync_s;

endpackage
`default_nettype wire

// ===== pin_sync.sv
// two-flop synchronisers for serial clock and data pins, with clock edge detect
`timescale 1ns/1ns
`default_nettype none
module pin_sync
    import sync_serial_pkg::*;
(
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic sck_in,
    input wire logic rxd,
    output logic sck_rise,
    output logic sck_fall,
    output logic rxd_s
);
    pin_sync_s r;
    pin_sync_s s;

    // edge detect looks only at the second and third stages
    always_comb begin
        s.sck = {r.sck[1:0], sck_in};
        s.rxd = {r.rxd[0], rxd};
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            r <= '1;
        end else begin
            r <= s;
        end
    end

    assign sck_rise = r.sck[1] & ~r.sck[2];
    assign sck_fall = ~r.sck[1] & r.sck[2];
    assign rxd_s = r.rxd[1];
endmodule
`default_nettype wire

// ===== sync_serial_channel_txrx.sv
// one serial channel in clocked synchronous mode: shifters, flags, requests
`timescale 1ns/1ns
`default_nettype none
module sync_serial_channel_txrx
    import sync_serial_pkg::*;
(
    input wire logic core_clk,
    input wire logic arst_n,
    input wire ctrl_s ctrl,
    input wire logic [`SS_DIV_W-1:0] bit_rate_reg,
    input wire logic tx_buf_wr,
    input wire logic dma_tx_wr,
    input wire logic [`SS_DATA_W-1:0] tx_wdata,
    input wire logic dma_rx_rd,
    input wire flags_s flag_clear,
    input wire logic framing_err_set,
    input wire logic parity_err_set,
    input wire logic sck_in,
    input wire logic rxd,
    output logic sck_out,
    output logic sck_oe,
    output logic txd,
    output flags_s flags,
    output logic [`SS_DATA_W-1:0] rx_buffer,
    output requests_s requests,
    output logic [2:0] irq_code
);
    chan_state_s r;
    chan_state_s s;
    flags_s fs;
    flags_s clr;
    logic halt;
    logic rise;
    logic fall;
    logic frame_end;
    logic rx_set;
    logic ext_rise;
    logic ext_fall;
    logic rxd_s;

    // the receiver runs on its own only when the partner clocks or nothing is sent
    function automatic logic rx_free_run(input ctrl_s c);
        return c.rx_enable && (!c.clk_internal || !c.tx_enable);
    endfunction

    pin_sync u_pin_sync (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .sck_in(sck_in),
        .rxd(rxd),
        .sck_rise(ext_rise),
        .sck_fall(ext_fall),
        .rxd_s(rxd_s)
    );

    // next-state logic for the whole channel
    always_comb begin
        s = r;
        fs = '0;
        rise = 1'b0;
        fall = 1'b0;
        frame_end = 1'b0;
        rx_set = 1'b0;
        halt = r.flags.overrun | r.flags.framing_err | r.flags.parity_err;
        // serial clock edges: own divider or the partner's clock
        if (ctrl.clk_internal) begin
            if (r.st == ST_RUN) begin
                if (r.div == '0) begin
                    s.div = bit_rate_reg;
                    s.sck = ~r.sck;
                    fall = r.sck;
                    rise = ~r.sck;
                end else begin
                    s.div = r.div - 1'b1;
                end
            end
        end else begin
            rise = ext_rise && (r.st == ST_RUN);
            fall = ext_fall && (r.st == ST_RUN);
            // mirror the partner's clock so the frame position is known; pin not driven here
            if (fall) begin
                s.sck = 1'b0;
            end else if (rise) begin
                s.sck = 1'b1;
            end
        end
        case (r.st)
            ST_IDLE: begin
                s.sck = 1'b1;
                s.bit_cnt = '0;
                s.div = bit_rate_reg;
                if (!halt && ctrl.tx_enable && !r.flags.tx_empty) begin
                    // buffer to shifter; first bit is put on the line at once
                    s.tx_shift = r.tx_buf;
                    s.txd = r.tx_buf[0];
                    s.tx_live = 1'b1;
                    fs.tx_empty = 1'b1;
                    s.st = ST_RUN;
                end else if (!halt && rx_free_run(ctrl)) begin
                    s.tx_live = 1'b0;
                    s.st = ST_RUN;
                end
            end
            ST_RUN: begin
                if (halt || (!ctrl.rx_enable && !(r.tx_live && ctrl.tx_enable))) begin
                    // an error aborts the frame; sck parks high
                    s.st = ST_IDLE;
                    s.sck = 1'b1;
                    s.chain = 1'b0;
                end else begin
                    // a byte written while only the receiver runs joins at a frame gap;
                    // sck high with no bit counted means no bit of this frame has left yet
                    if (!r.tx_live && r.sck && !fall && (r.bit_cnt == '0) &&
                        ctrl.tx_enable && !r.flags.tx_empty) begin
                        s.tx_shift = r.tx_buf;
                        s.txd = r.tx_buf[0];
                        s.tx_live = 1'b1;
                        fs.tx_empty = 1'b1;
                    end
                    if (fall && r.tx_live) begin
                        s.txd = r.tx_shift[r.bit_cnt[2:0]];
                        if (r.bit_cnt == `SS_LAST_BIT) begin
                            // txd takes the MSB from the old shifter in this cycle, so the shifter can reload now
                            if (ctrl.tx_enable && !r.flags.tx_empty) begin
                                s.chain = 1'b1;
                                s.tx_shift = r.tx_buf;
                                fs.tx_empty = 1'b1;
                            end else begin
                                fs.tx_end = 1'b1;
                            end
                        end
                    end
                    if (rise) begin
                        s.rx_shift = {rxd_s, r.rx_shift[7:1]};
                        s.bit_cnt = r.bit_cnt + 1'b1;
                        if (r.bit_cnt == `SS_LAST_BIT) begin
                            // eighth rising edge closes the character
                            frame_end = 1'b1;
                            s.bit_cnt = '0;
                            s.tx_live = r.chain;
                            s.chain = 1'b0;
                            if (ctrl.rx_enable) begin
                                if (!r.flags.rx_full) begin
                                    rx_set = 1'b1;
                                    s.rx_buf = {rxd_s, r.rx_shift[7:1]};
                                    fs.rx_full = 1'b1;
                                end else begin
                                    fs.overrun = 1'b1;
                                end
                            end
                            if (!(r.chain || rx_free_run(ctrl))) begin
                                s.st = ST_IDLE;
                            end
                        end
                    end
                end
            end
            default: begin
                s.st = ST_IDLE;
            end
        endcase
        // transmitter disable wins over the shifter, txd, tx_live, chain and tx_empty; a buffer write in the same cycle still lands
        if (!ctrl.tx_enable) begin
            fs.tx_empty = 1'b1;
            s.tx_shift = '0;
            s.tx_live = 1'b0;
            s.chain = 1'b0;
            s.txd = `SS_TXD_RST;
        end
        // a write while tx_empty is low overwrites the unsent byte
        if (tx_buf_wr || dma_tx_wr) begin
            s.tx_buf = tx_wdata;
        end
        fs.framing_err = framing_err_set;
        fs.parity_err = parity_err_set;
        clr = flag_clear;
        clr.tx_empty = flag_clear.tx_empty | dma_tx_wr;
        clr.rx_full = flag_clear.rx_full | dma_rx_rd;
        // set wins over clear; receive enable plays no part here
        s.flags = flags_s'(fs | (r.flags & ~clr));
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            r <= '0;
            r.flags.tx_empty <= `SS_TX_EMPTY_RST;
            r.flags.tx_end <= `SS_TX_END_RST;
            r.txd <= `SS_TXD_RST;
            r.sck <= `SS_SCK_RST;
        end else begin
            r <= s;
        end
    end

    // request lines, each gated by its enable
    always_comb begin
        requests.rx_error = ctrl.rx_irq_enable &&
            (r.flags.overrun || r.flags.framing_err || r.flags.parity_err);
        requests.rx_full = ctrl.rx_irq_enable && r.flags.rx_full;
        requests.tx_empty = ctrl.tx_irq_enable && r.flags.tx_empty;
        requests.tx_end = ctrl.tx_end_irq_enable && r.flags.tx_end;
    end

    // fixed priority code of the highest pending request
    always_comb begin
        if (requests.rx_error) begin
            irq_code = `SS_IRQ_RX_ERROR;
        end else if (requests.rx_full) begin
            irq_code = `SS_IRQ_RX_FULL;
        end else if (requests.tx_empty) begin
            irq_code = `SS_IRQ_TX_EMPTY;
        end else if (requests.tx_end) begin
            irq_code = `SS_IRQ_TX_END;
        end else begin
            irq_code = `SS_IRQ_NONE;
        end
    end

    assign sck_out = r.sck;
    assign sck_oe = ctrl.clk_internal;
    assign txd = r.txd;
    assign flags = r.flags;
    assign rx_buffer = r.rx_buf;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!arst_n);

    sequence s_last_fall;
        fall && r.tx_live && (r.bit_cnt == `SS_LAST_BIT) && ctrl.tx_enable;
    endsequence

    sequence s_full_collision;
        frame_end && ctrl.rx_enable && r.flags.rx_full;
    endsequence

    a_tx_disable_empty: assert property (
        !ctrl.tx_enable |=> flags.tx_empty && txd && !r.tx_live)
        else $error("tx disable did not set tx_empty");
    a_rx_disable_keep: assert property (
        $fell(ctrl.rx_enable) && flag_clear == '0 && !dma_rx_rd && !rx_set
        |=> $stable(rx_buffer) && flags.rx_full == $past(flags.rx_full))
        else $error("rx disable disturbed receive state");
    a_dma_tx_clear: assert property (
        dma_tx_wr && ctrl.tx_enable |=> !flags.tx_empty)
        else $error("dma write left tx_empty set");
    a_dma_rx_clear: assert property (
        dma_rx_rd && !rx_set |=> !flags.rx_full)
        else $error("dma read left rx_full set");
    a_err_blocks_full: assert property (
        flags.framing_err || flags.parity_err |=> !$rose(flags.rx_full) && r.st == ST_IDLE)
        else $error("receive continued under framing or parity error");
    a_overrun_halts: assert property (
        flags.overrun |=> r.st == ST_IDLE ##0 (!rise)[*2])
        else $error("link ran with overrun set");
    a_overrun_on_full: assert property (
        s_full_collision |=> flags.overrun && $stable(rx_buffer))
        else $error("full collision not flagged as overrun");
    a_msb_check: assert property (
        s_last_fall ##0 flags.tx_empty |=> flags.tx_end && txd == $past(r.tx_shift[7]))
        else $error("transmit end not set at last bit");
    a_err_request: assert property (
        flags.overrun && ctrl.rx_irq_enable |-> requests.rx_error && irq_code == `SS_IRQ_RX_ERROR)
        else $error("error request missing or outranked");
    a_sck_idle_high: assert property (
        r.st == ST_IDLE |=> sck_out)
        else $error("serial clock not high while idle");
    a_line_holds: assert property (
        rise && ctrl.tx_enable |=> $stable(txd))
        else $error("txd changed on a rising edge");
endmodule
`default_nettype wire

// ===== serial_partner.sv
// far-side device model: shares the serial clock, sends and collects bytes
`timescale 1ns/1ns
`default_nettype none
module serial_partner (
    input wire logic clk_internal,
    input wire logic sck_out,
    input wire logic txd,
    output logic sck_in,
    output logic rxd,
    output logic [7:0] got,
    output int n_got
);
    logic [7:0] send_q[$];
    logic [7:0] cur;
    logic [7:0] sh;
    int k;
    wire logic sck = clk_internal ? sck_out : sck_in;

    initial begin
        sck_in = 1'b1;
        rxd = 1'b1;
        got = 8'h00;
        n_got = 0;
        k = 0;
        cur = 8'h00;
        sh = 8'h00;
    end

    // next bit leaves on each fall, eight data bits, then the rise block toggles the line after the eighth
    always @(negedge sck) begin
        if (k == 0) begin
            cur = (send_q.size() > 0) ? send_q.pop_front() : 8'h00;
        end
        rxd <= cur[k];
    end

    // sample on the rise, LSB first; line toggled once its hold is over
    always @(posedge sck) begin
        sh = {txd, sh[7:1]};
        k = k + 1;
        if (k == 8) begin
            got = sh;
            n_got = n_got + 1;
            k = 0;
            #40 rxd = ~rxd;
        end
    end

    // external clock: eight pulses, high between frames; lead-in gives setup time
    task automatic ext_frame();
        #203;
        repeat (8) begin
            #80 sck_in = 1'b0;
            #80 sck_in = 1'b1;
        end
    endtask
endmodule
`default_nettype wire

// ===== sync_serial_channel_txrx_bench.sv
// self-checking bench for the synchronous serial channel
`timescale 1ns/1ns
`default_nettype none
module sync_serial_channel_txrx_bench;
    import sync_serial_pkg::*;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    ctrl_s ctrl = '0;
    logic [7:0] bit_rate_reg = 8'h07;
    logic tx_buf_wr = 1'b0;
    logic dma_tx_wr = 1'b0;
    logic [7:0] tx_wdata = 8'h00;
    logic dma_rx_rd = 1'b0;
    flags_s flag_clear = '0;
    logic framing_err_set = 1'b0;
    logic parity_err_set = 1'b0;
    logic sck_in, rxd, sck_out, sck_oe, txd;
    flags_s flags, exp_f;
    requests_s requests;
    logic [2:0] irq_code;
    logic [7:0] rx_buffer, exp_buf, got, b, r, b2, r2;
    int n_got, n_fail = 0, cmp_count = 0, nfall = 0;
    integer seed = 52218;

    sync_serial_channel_txrx i_dut (.core_clk(core_clk), .arst_n(arst_n), .ctrl(ctrl),
        .bit_rate_reg(bit_rate_reg), .tx_buf_wr(tx_buf_wr), .dma_tx_wr(dma_tx_wr),
        .tx_wdata(tx_wdata), .dma_rx_rd(dma_rx_rd), .flag_clear(flag_clear),
        .framing_err_set(framing_err_set), .parity_err_set(parity_err_set),
        .sck_in(sck_in), .rxd(rxd), .sck_out(sck_out), .sck_oe(sck_oe), .txd(txd),
        .flags(flags), .rx_buffer(rx_buffer), .requests(requests), .irq_code(irq_code));
    serial_partner i_partner (.clk_internal(ctrl.clk_internal), .sck_out(sck_out),
        .txd(txd), .sck_in(sck_in), .rxd(rxd), .got(got), .n_got(n_got));

    always #5 core_clk = ~core_clk;
    always @(negedge sck_out) nfall++;

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // requests and priority code follow from the modelled flags, not the design's
    task automatic check_all();
        requests_s q;
        logic [2:0] c;
        q.rx_error = ctrl.rx_irq_enable & (exp_f.overrun | exp_f.framing_err | exp_f.parity_err);
        q.rx_full = ctrl.rx_irq_enable & exp_f.rx_full;
        q.tx_empty = ctrl.tx_irq_enable & exp_f.tx_empty;
        q.tx_end = ctrl.tx_end_irq_enable & exp_f.tx_end;
        c = q.rx_error ? 3'h1 : q.rx_full ? 3'h2 : q.tx_empty ? 3'h3 : q.tx_end ? 3'h4 : 3'h0;
        check("flags", {2'h0, flags}, {2'h0, exp_f});
        check("rx_buffer", rx_buffer, exp_buf);
        check("requests", {4'h0, requests}, {4'h0, q});
        check("irq_code", {5'h00, irq_code}, {5'h00, c});
    endtask

    task automatic strobe_clear(input flags_s f);
        @(negedge core_clk);
        flag_clear = f;
        @(negedge core_clk);
        flag_clear = '0;
        exp_f = flags_s'(exp_f & ~f);
    endtask

    task automatic dma_read();
        @(negedge core_clk);
        dma_rx_rd = 1'b1;
        @(negedge core_clk);
        dma_rx_rd = 1'b0;
        exp_f.rx_full = 1'b0;
    endtask

    // software write then clear of the empty flag, or one DMA write
    task automatic put_tx(input logic [7:0] v, input logic [7:0] rv, input logic dma);
        i_partner.send_q.push_back(rv);
        @(negedge core_clk);
        tx_wdata = v;
        tx_buf_wr = ~dma;
        dma_tx_wr = dma;
        @(negedge core_clk);
        tx_buf_wr = 1'b0;
        dma_tx_wr = 1'b0;
        if (!dma) begin
            strobe_clear(6'h20);
        end
        exp_f.tx_empty = 1'b0;
    endtask

    // waits are short so a chained frame's first fall is not yet counted
    task automatic finish_frame(input logic [7:0] v, input logic [7:0] rv, input logic last);
        int n0;
        n0 = n_got;
        if (!ctrl.clk_internal) begin
            i_partner.ext_frame();
        end
        for (int i = 0; i < 400 && n_got == n0; i++) begin
            @(negedge core_clk);
        end
        repeat (ctrl.clk_internal ? 5 : 8) @(negedge core_clk);
        exp_f.tx_empty = 1'b1;
        exp_f.tx_end = exp_f.tx_end | last;
        exp_f.overrun = exp_f.overrun | exp_f.rx_full;
        if (!exp_f.rx_full) begin
            exp_buf = rv;
        end
        exp_f.rx_full = 1'b1;
        check("byte on line", got, v);
        if (ctrl.clk_internal) begin
            check("clock falls", nfall[7:0], 8'h08);
        end
        nfall = 0;
        check_all();
    endtask

    // an error flag halts the link until software clears it
    task automatic blocked_frame(input logic [7:0] v, input logic [7:0] rv, input flags_s err);
        put_tx(v, rv, 1'b0);
        repeat (60) @(negedge core_clk);
        check("falls while halted", nfall[7:0], 8'h00);
        check_all();
        strobe_clear(err);
        finish_frame(v, rv, 1'b1);
        $display("test halted frame done");
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        #200000;
        n_fail++;
        $display("BAD watchdog expected end seen hang");
        tally_and_finish();
    end

    initial begin
        exp_f = flags_s'(6'h30);
        exp_buf = 8'h00;
        repeat (5) @(negedge core_clk);
        arst_n = 1'b1;
        i_partner.k = 0;
        check("idle txd", {7'h00, txd}, 8'h01);
        check("idle clock", {7'h00, sck_out}, 8'h01);
        check_all();
        $display("test reset done");
        // clock source chosen with enables off, twenty core clocks before enabling
        ctrl.clk_internal = 1'b1;
        repeat (20) @(negedge core_clk);
        ctrl = 6'h3F;
        @(negedge core_clk);
        check("clock drive on", {7'h00, sck_oe}, 8'h01);
        for (int i = 0; i < 4; i++) begin
            b = 8'($random(seed));
            r = 8'($random(seed));
            put_tx(b, r, i[0]);
            finish_frame(b, r, 1'b1);
            dma_read();
            check_all();
        end
        $display("test single frames done");
        // chained pair, next byte written before the MSB; no read gives an overrun
        strobe_clear(6'h10);
        b = 8'($random(seed));
        r = 8'($random(seed));
        b2 = 8'($random(seed));
        r2 = 8'($random(seed));
        put_tx(b, r, 1'b0);
        for (int i = 0; i < 20 && flags.tx_empty !== 1'b1; i++) @(negedge core_clk);
        put_tx(b2, r2, 1'b0);
        finish_frame(b, r, 1'b0);
        finish_frame(b2, r2, 1'b1);
        $display("test chained frames done");
        dma_read();
        check_all();
        blocked_frame(8'($random(seed)), 8'($random(seed)), 6'h04);
        for (int e = 0; e < 2; e++) begin
            dma_read();
            framing_err_set = (e == 0);
            parity_err_set = (e == 1);
            @(negedge core_clk);
            framing_err_set = 1'b0;
            parity_err_set = 1'b0;
            exp_f = flags_s'(exp_f | (e == 0 ? 6'h02 : 6'h01));
            blocked_frame(8'($random(seed)), 8'($random(seed)), e == 0 ? 6'h02 : 6'h01);
        end
        // both enables dropped in mid-frame with a byte waiting
        put_tx(8'hA5, 8'h3C, 1'b0);
        repeat (40) @(negedge core_clk);
        put_tx(8'h5A, 8'hC3, 1'b0);
        ctrl.tx_enable = 1'b0;
        ctrl.rx_enable = 1'b0;
        repeat (3) @(negedge core_clk);
        exp_f.tx_empty = 1'b1;
        check("txd after disable", {7'h00, txd}, 8'h01);
        check_all();
        $display("test disable done");
        i_partner.k = 0;
        i_partner.send_q.delete();
        ctrl.clk_internal = 1'b0;
        repeat (20) @(negedge core_clk);
        ctrl.tx_enable = 1'b1;
        ctrl.rx_enable = 1'b1;
        dma_read();
        check("clock drive enable", {7'h00, sck_oe}, 8'h00);
        b = 8'($random(seed));
        r = 8'($random(seed));
        put_tx(b, r, 1'b1);
        finish_frame(b, r, 1'b1);
        $display("test external clock done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
